/* File: gpio_pad_model.sv */
// pad wire model: the port drives or the outside level shows
`timescale 1ns/1ps
module gpio_pad_model (
  input  wire logic [15:0] pinOut, pinOutEn, outside,
  output logic      [15:0] pinIn
);
  assign pinIn = (pinOutEn & pinOut) | (~pinOutEn & outside);
endmodule // gpio_pad_model

/* File: gpio_port_pkg.sv */
// constants for the shared parallel i/o port
package gpio_port_pkg;
  localparam int          PortWidth       = 16;
  localparam logic [31:0] PortMask        = 32'h0000_ffff;
  localparam logic [15:0] ImplementedBits = 16'hffff;
  localparam logic [15:0] DirReset        = 16'hffff;
  localparam logic [15:0] LatchReset      = 16'h0000;
  localparam logic [15:0] AnalogReset     = 16'h0000;
  localparam logic [11:0] DirOffset       = 12'h000;
  localparam logic [11:0] PinOffset       = 12'h004;
  localparam logic [11:0] LatchOffset     = 12'h008;
  localparam logic [11:0] AnalogOffset    = 12'h00c;
  localparam logic [11:0] OwnerOffset     = 12'h010;
  localparam logic [31:0] ReadZero        = 32'h0000_0000;
endpackage

/* File: gpio_port_props.sv */
// checker for the shared port, bound to its ports
`timescale 1ns/1ps
module gpio_port_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOutEn,
  input wire logic [15:0] periphEnable,
  input wire logic [15:0] periphDriving,
  input wire logic [15:0] periphOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic [15:0] own = periphEnable & periphDriving;
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_err_unmapped: assert property (psel && !penable && paddr > 12'h010 |=> pslverr) else $error("no error");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000) else $error("idle data");
  a_upper_bits_zero: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper bits");
  a_owner_data: assert property (!$past(reset) |-> (pinOut & $past(own)) == ($past(periphOut) & $past(own)))
    else $error("owner data");
  a_owner_enable: assert property (!$past(reset) |-> ($past(own) & ~pinOutEn) == 16'h0000)
    else $error("owner enable");
  a_reset_inputs: assert property ($fell(reset) |-> pinOutEn == 16'h0000) else $error("pads driven");
endmodule // gpio_port_props
bind shared_parallel_io_port gpio_port_props u_gpio_port_props (.*);

/* File: shared_parallel_io_port.sv */
// shared parallel i/o port with apb register access
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module shared_parallel_io_port (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] pinIn,
  output logic      [15:0] pinOut,
  output logic      [15:0] pinOutEn,
  input  wire logic [15:0] periphEnable,
  input  wire logic [15:0] periphDriving,
  input  wire logic [15:0] periphOut,
  output logic      [15:0] analogEnable
);
  // register state
  logic [15:0] dir_q;

  logic [15:0] latch_q;

  logic [15:0] analog_q;

  logic [15:0] pinSync_q;

  // bus phase decode
  logic        setup;

  logic        access;

  logic        wrStrobe;

  logic        wrDir;

  logic        wrLatch;

  logic        wrAnalog;

  // pad mux results
  logic [15:0] owner;

  logic [15:0] padData;

  logic [15:0] padEnable;

  // read views, one per register
  logic [15:0] dirView;

  logic [15:0] latchView;

  logic [15:0] pinView;

  logic [15:0] analogView;

  logic [15:0] ownerView;

  logic [31:0] rdata_d;

  logic        rdHit_d;

  // word write data masked to implemented bits
  function automatic logic [15:0] implBits(input logic [31:0] v);

    implBits = v[15:0] & gpio_port_pkg::ImplementedBits;

  endfunction

  // a 16-bit view as a bus word, upper half reads zero
  function automatic logic [31:0] toWord(input logic [15:0] v);

    toWord = {16'h0000, v};

  endfunction

  // exact word address match
  function automatic logic isAddr(
    input logic [11:0] a,
    input logic [11:0] offset
  );

    isAddr = (a == offset);

  endfunction

  // mapped word addresses; anything else is refused
  function automatic logic isMapped(input logic [11:0] a);

    isMapped = isAddr(a, gpio_port_pkg::DirOffset) ||
               isAddr(a, gpio_port_pkg::PinOffset) ||
               isAddr(a, gpio_port_pkg::LatchOffset) ||
               isAddr(a, gpio_port_pkg::AnalogOffset) ||
               isAddr(a, gpio_port_pkg::OwnerOffset);

  endfunction

  // pad owner per pin: enabled and actively driving
  function automatic logic [15:0] ownedBits(
    input logic [15:0] enabled,
    input logic [15:0] driving
  );

    ownedBits = enabled & driving;

  endfunction

  // pin levels as software sees them; analog pins read low
  function automatic logic [15:0] digitalLevels(
    input logic [15:0] levels,
    input logic [15:0] analog
  );

    digitalLevels = levels & ~analog & gpio_port_pkg::ImplementedBits;

  endfunction

  // setup cycle: the read answer is prepared here
  assign setup = psel && !penable;

  // access cycle with ready high: the only edge at which a write lands
  assign access = psel && penable && pready;

  assign wrStrobe = access && pwrite;

  assign wrDir = wrStrobe && isAddr(paddr, gpio_port_pkg::DirOffset);

  // the pin-value address writes the latch as well
  assign wrLatch = wrStrobe &&
                   (isAddr(paddr, gpio_port_pkg::LatchOffset) ||
                    isAddr(paddr, gpio_port_pkg::PinOffset));

  assign wrAnalog = wrStrobe && isAddr(paddr, gpio_port_pkg::AnalogOffset);

  // input-only functions never own a pad, so the port stays the source
  assign owner = ownedBits(periphEnable, periphDriving);

  // one pad cell per pin; the peripheral has priority in both muxes
  for (genvar i = 0; i < gpio_port_pkg::PortWidth; i++) begin : gen_pad

    logic portDrives;

    assign portDrives = ~dir_q[i] & gpio_port_pkg::ImplementedBits[i];

    assign padData[i] = owner[i] ? periphOut[i] : latch_q[i];

    assign padEnable[i] = owner[i] | portDrives;

  end

  // direction register, a set bit keeps the port from driving that pad
  always_ff @(posedge mclk) begin

    if (reset) begin
      dir_q <= gpio_port_pkg::DirReset;
    end

    else if (wrDir) begin
      dir_q <= implBits(pwdata) | ~gpio_port_pkg::ImplementedBits;
    end

  end

  // latch written directly or through the pin-value address
  always_ff @(posedge mclk) begin

    if (reset) begin
      latch_q <= gpio_port_pkg::LatchReset;
    end

    else if (wrLatch) begin
      latch_q <= implBits(pwdata);
    end

  end

  // analog select, one bit per pin
  always_ff @(posedge mclk) begin

    if (reset) begin
      analog_q <= gpio_port_pkg::AnalogReset;
    end

    else if (wrAnalog) begin
      analog_q <= implBits(pwdata);
    end

  end

  // one stage only; inputs are already synchronous to mclk
  always_ff @(posedge mclk) begin

    if (reset) begin
      pinSync_q <= '0;
    end

    else begin
      pinSync_q <= pinIn;
    end

  end

  // pad data from a flip-flop, one cycle behind the mux
  always_ff @(posedge mclk) begin

    if (reset) begin
      pinOut <= '0;
    end

    else begin
      pinOut <= padData;
    end

  end

  // pad enable; reset leaves every pad undriven
  always_ff @(posedge mclk) begin

    if (reset) begin
      pinOutEn <= '0;
    end

    else begin
      pinOutEn <= padEnable;
    end

  end

  // digital inputs never reach the converter
  always_ff @(posedge mclk) begin

    if (reset) begin
      analogEnable <= '0;
    end

    else begin
      analogEnable <= analog_q;
    end

  end

  // read views; unimplemented bits read zero
  assign dirView = dir_q & gpio_port_pkg::ImplementedBits;

  assign latchView = latch_q & gpio_port_pkg::ImplementedBits;

  assign pinView = digitalLevels(pinSync_q, analog_q);

  assign analogView = analog_q & gpio_port_pkg::ImplementedBits;

  assign ownerView = owner & gpio_port_pkg::ImplementedBits;

  assign rdHit_d = isMapped(paddr);

  always_comb begin

    rdata_d = gpio_port_pkg::ReadZero;
    unique case (paddr)
      gpio_port_pkg::DirOffset: begin
        rdata_d = toWord(dirView);
      end

      gpio_port_pkg::LatchOffset: begin
        rdata_d = toWord(latchView);
      end

      gpio_port_pkg::PinOffset: begin
        rdata_d = toWord(pinView);
      end

      gpio_port_pkg::AnalogOffset: begin
        rdata_d = toWord(analogView);
      end

      gpio_port_pkg::OwnerOffset: begin
        rdata_d = toWord(ownerView);
      end

      default: begin
        rdata_d = gpio_port_pkg::ReadZero;
      end
    endcase

  end

  // read data stands only in the access cycle; writes read back zero
  always_ff @(posedge mclk) begin

    if (reset) begin
      prdata <= gpio_port_pkg::ReadZero;
    end

    else if (setup && !pwrite) begin
      prdata <= rdata_d;
    end

    else begin
      prdata <= gpio_port_pkg::ReadZero;
    end

  end

  // no wait states: ready follows every setup cycle
  // a read one idle cycle after a write sees settled registers
  always_ff @(posedge mclk) begin

    if (reset) begin
      pready <= 1'b0;
    end

    else begin
      pready <= setup;
    end

  end

  // refused only on an unmapped address, and only alongside ready
  always_ff @(posedge mclk) begin

    if (reset) begin
      pslverr <= 1'b0;
    end

    else begin
      pslverr <= setup && !rdHit_d;
    end

  end

endmodule // shared_parallel_io_port

/* File: tb_top.sv */
// apb bench for the shared port
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, gotErr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, got;
  logic [15:0] pinIn, pinOut, pinOutEn, analogEnable, pEn = 16'h0000, pDrv = 16'h0000, pOut = 16'h0000;
  int          err_total = 0, check_count = 0, cyc = 0;
  shared_parallel_io_port u_shared_parallel_io_port (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOutEn, .periphEnable(pEn),
    .periphDriving(pDrv), .periphOut(pOut), .analogEnable);
  gpio_pad_model u_gpio_pad_model (.pinOut, .pinOutEn, .outside(16'h3c00), .pinIn);
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 4000) begin err_total++; conclude(); end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin err_total++; $display("MISMATCH %s exp %h got %h", what, exp, seen); end
  endtask
  // idle edge at the end keeps a gap before the next read of the port
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    got = prdata; gotErr = pslverr;
    psel <= 0; penable <= 0;
    @(posedge mclk);
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp, input logic e);
    xfer(0, a, 32'h0000_0000);
    chk(what, exp, got);
    chk("slverr", {31'h0, e}, {31'h0, gotErr});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 0;
    rd("dir", gpio_port_pkg::DirOffset, 32'h0000_ffff, 0);
    rd("latch", gpio_port_pkg::LatchOffset, 32'h0000_0000, 0);
    chk("pad enable", 32'h0, {16'h0, pinOutEn});
    xfer(1, gpio_port_pkg::DirOffset, 32'hffff_ff00);
    xfer(1, gpio_port_pkg::PinOffset, 32'h0000_a5c3);
    xfer(1, gpio_port_pkg::AnalogOffset, 32'h0000_f000);
    rd("latch", gpio_port_pkg::LatchOffset, 32'h0000_a5c3, 0);
    rd("dir", gpio_port_pkg::DirOffset, 32'h0000_ff00, 0);
    rd("pins", gpio_port_pkg::PinOffset, 32'h0000_0cc3, 0);
    chk("pad enable", 32'h0000_00ff, {16'h0, pinOutEn});
    chk("analog", 32'h0000_f000, {16'h0, analogEnable});
    pEn <= 16'hffff; pDrv <= 16'h010f; pOut <= 16'h0105;
    repeat (3) @(posedge mclk);
    chk("pad data", 32'h0000_a5c5, {16'h0, pinOut});
    chk("pad enable", 32'h0000_01ff, {16'h0, pinOutEn});
    rd("pins", gpio_port_pkg::PinOffset, 32'h0000_0dc5, 0);
    rd("unmapped", 12'h020, 32'h0000_0000, 1);
    conclude();
  end
endmodule // tb_top
